// ==== hw/pwr_mode_pkg.sv ====
// Package: register map, field layout and types of the power mode controller
`default_nettype none
package pwr_mode_pkg;
  // ---------------------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADDR_MODE   = 8'h00;  // system mode register
  localparam logic [7:0] ADDR_CTRL   = 8'h04;  // idle keep, watchdog, detector
  localparam logic [7:0] ADDR_STATUS = 8'h08;  // power down, time-out, state
  localparam logic [7:0] ADDR_WAKE   = 8'h0C;  // port A wake enables
  localparam logic [7:0] ADDR_CMD    = 8'h10;  // halt / clear watchdog strobes
  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int MODE_HCS   = 0;   // high clock select
  localparam int MODE_IDLE  = 1;   // idle enable
  localparam int MODE_HRDY  = 2;   // high oscillator ready
  localparam int MODE_LRDY  = 3;   // low oscillator ready
  localparam int MODE_CKS_L = 5;   // clock divider select low bit
  localparam int CTRL_KEEP  = 7;   // idle clock keep
  localparam int CTRL_WDT   = 0;   // watchdog enabled
  localparam int CTRL_VDE   = 1;   // voltage detect enable
  localparam int CMD_HALT   = 0;
  localparam int CMD_CLRWDT = 1;
  // ---------------------------------------------------------------------------
  // Reset values and timing
  // ---------------------------------------------------------------------------
  localparam logic [2:0] CKS_RESET  = 3'h6;
  localparam logic [2:0] CKS_SUB_HI = 3'h1;  // 000/001 select the sub clock
  localparam int         HRDY_CYC   = 16;    // ready 15~16 cycles after wake
  localparam int         LRDY_CYC   = 2;     // ready 1~2 cycles after wake
  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_NORMAL, ST_SLOW, ST_DEEP, ST_SLEEP_SUB, ST_IDLE_SUB, ST_IDLE_RUN
  } pmode_t;

  typedef struct packed {
    logic sys_clk_en;    // system clock to the core
    logic high_osc_en;   // fast internal oscillator
    logic sub_clk_en;    // sub clock
    logic div16_64_en;   // timer sources from the high clock
    logic cpu_run;       // program execution
  } clk_gate_t;

  typedef struct packed {
    logic wdt_clear;     // one-cycle clear of the watchdog counter
    logic wdt_hold;      // counter held stopped
    logic pc_sp_reset;   // reset program counter and stack pointer only
    logic irq_take;      // take the interrupt response on wake
  } core_ctl_t;
endpackage
`default_nettype wire

// ==== hw/power_mode_and_wake_controller.sv ====
// Operating mode, clock gating and wake-up control for a small core
// Summary of operation
// RULE_01: Normal/slow switch by clock select bits; standby only via halt.
// RULE_02: Moving to sub clock stops the fast oscillator and its divided sources.
// RULE_03: Select bit 0 with divider 000 or 001 enters slow mode.
// RULE_04: Slow mode completes only once the low oscillator reports ready. Wake-up from deep sleep enters slow before low ready is set.
// RULE_05: Select bit 1, or divider 010 to 111, returns to normal.
// RULE_06: Software polls the high oscillator ready flag after returning.
// RULE_07: Permanent watchdog keeps the sub clock on; no deep sleep.
// RULE_08: Halt, idle off, watchdog and detector off: deep sleep, clocks stop.
// RULE_09: Deep sleep clears and holds the watchdog counter.
// RULE_10: Halt, idle off, watchdog or detector on: sleep with sub clock.
// RULE_11: Halt, idle on, keep off: sub-only idle, watchdog restarts.
// RULE_12: Halt, idle on, keep on: both clocks run, execution halts.
// RULE_13: Standby keeps memory, registers and port states unchanged.
// RULE_14: Standby entry sets power-down flag and clears time-out flag.
// RULE_15: Wake on enabled port A falling edge, interrupt or watchdog overflow.
// RULE_16: Overflow in standby sets time-out, resets only PC and SP.
// RULE_17: Power-down flag clears on power-up or clear-watchdog, sets on halt.
// RULE_18: Each port A pin has a wake enable; resume after halt.
// RULE_19: Disabled or stack-full interrupt wake resumes; request stays pending.
// RULE_20: Enabled interrupt with free stack level is serviced on wake.
// RULE_21: Interrupt already pending before standby does not wake.
// RULE_22: Divider selects sub clock or high clock divided by 64 down to 2.
// RULE_23: High ready low in deep sleep/sub idle; high 15-16 cycles after wake.
// RULE_24: Detector enabled keeps detector, bandgap and sub clock on in standby.
// RULE_25: Wake-up resumes normal or slow per the held clock select settings.
`default_nettype none
module power_mode_and_wake_controller
  import pwr_mode_pkg::*;
#(
  parameter int         PA_W      = 8,     // port A pins
  parameter int         IRQ_W     = 4,     // interrupt sources
  parameter logic       WDT_ALWAYS = 1'b0  // watchdog permanently enabled
) (
  input  wire logic              clk_sys,      // 125 MHz system clock
  input  wire logic              srst,         // synchronous reset, high
  input  wire logic [7:0]        s_awaddr,     // AXI write address
  input  wire logic              s_awvalid,    // AXI write address valid
  output logic                   s_awready,    // AXI write address ready
  input  wire logic [31:0]       s_wdata,      // AXI write data
  input  wire logic [3:0]        s_wstrb,      // AXI write strobes
  input  wire logic              s_wvalid,     // AXI write data valid
  output logic                   s_wready,     // AXI write data ready
  output logic [1:0]             s_bresp,      // AXI write response
  output logic                   s_bvalid,     // AXI write response valid
  input  wire logic              s_bready,     // AXI write response ready
  input  wire logic [7:0]        s_araddr,     // AXI read address
  input  wire logic              s_arvalid,    // AXI read address valid
  output logic                   s_arready,    // AXI read address ready
  output logic [31:0]            s_rdata,      // AXI read data
  output logic [1:0]             s_rresp,      // AXI read response
  output logic                   s_rvalid,     // AXI read valid
  input  wire logic              s_rready,     // AXI read ready
  input  wire logic [PA_W-1:0]   porta_pin,    // port A pins, asynchronous
  input  wire logic [IRQ_W-1:0]  irq_flag,     // interrupt request flags
  input  wire logic [IRQ_W-1:0]  irq_enable,   // interrupt enables
  input  wire logic              stack_full,   // no free stack level
  input  wire logic              wdt_overflow, // watchdog overflow pulse
  output clk_gate_t              clk_gate,     // clock gating controls
  output core_ctl_t              core_ctl,     // core side controls
  output logic [2:0]             sys_div_sel,  // divider select toward clocks
  output logic                   vd_keep_on    // detector and bandgap kept on
);
  import pwr_mode_pkg::*;

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  logic            high_clock_select;
  logic            idle_enable;
  logic [2:0]      clock_divider_select;
  logic            idle_clock_keep;
  logic            wdt_enable;
  logic            voltage_detect_enable;
  logic [PA_W-1:0] porta_wake_enable;
  logic            power_down_flag;
  logic            timeout_flag;
  logic            high_osc_ready;
  logic            low_osc_ready;
  pmode_t          mode;
  logic [4:0]      hrdy_cnt;
  logic [1:0]      lrdy_cnt;
  logic [IRQ_W-1:0] irq_armed;
  logic [PA_W-1:0] pa_s1, pa_s2, pa_s3;

  // Write channel capture, address and data in either order
  logic [7:0]  aw_q;
  logic [31:0] w_q;
  logic [3:0]  ws_q;
  logic        aw_have, w_have;
  logic        wr_go, halt_req, clrwdt_req;
  logic        wr_mode, wr_ctrl, wr_wake, wr_cmd, wr_ok;

  assign wr_go   = aw_have && w_have && !s_bvalid;
  assign wr_mode = wr_go && aw_q == ADDR_MODE && ws_q[0];
  assign wr_ctrl = wr_go && aw_q == ADDR_CTRL && ws_q[0];
  assign wr_wake = wr_go && aw_q == ADDR_WAKE && ws_q[0];
  assign wr_cmd  = wr_go && aw_q == ADDR_CMD && ws_q[0];
  assign wr_ok   = aw_q == ADDR_MODE || aw_q == ADDR_CTRL ||
                   aw_q == ADDR_WAKE || aw_q == ADDR_CMD ||
                   aw_q == ADDR_STATUS;
  assign halt_req   = wr_cmd && w_q[CMD_HALT];
  assign clrwdt_req = wr_cmd && w_q[CMD_CLRWDT];

  // ---------------------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      aw_have  <= 1'b0;
      w_have   <= 1'b0;
      aw_q     <= 8'h00;
      w_q      <= 32'h0000_0000;
      ws_q     <= 4'h0;
      s_bvalid <= 1'b0;
      s_bresp  <= AXI_OKAY;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_have <= 1'b1;
        aw_q    <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_have <= 1'b1;
        w_q    <= s_wdata;
        ws_q   <= s_wstrb;
      end
      if (wr_go) begin
        aw_have  <= 1'b0;
        w_have   <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp  <= wr_ok ? AXI_OKAY : AXI_SLVERR;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_awready <= 1'b0;
      s_wready  <= 1'b0;
    end else begin
      s_awready <= !aw_have && !(s_awvalid && s_awready) && !s_bvalid;
      s_wready  <= !w_have && !(s_wvalid && s_wready) && !s_bvalid;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_arready <= 1'b0;
      s_rvalid  <= 1'b0;
      s_rdata   <= 32'h0000_0000;
      s_rresp   <= AXI_OKAY;
    end else begin
      s_arready <= !s_rvalid && !(s_arvalid && s_arready);
      if (s_arvalid && s_arready) begin
        s_rvalid <= 1'b1;
        s_rresp  <= AXI_OKAY;
        s_rdata  <= 32'h0000_0000;
        case (s_araddr)
          ADDR_MODE: begin
            s_rdata[MODE_HCS]  <= high_clock_select;
            s_rdata[MODE_IDLE] <= idle_enable;
            s_rdata[MODE_HRDY] <= high_osc_ready;
            s_rdata[MODE_LRDY] <= low_osc_ready;
            s_rdata[MODE_CKS_L +: 3] <= clock_divider_select;
          end
          ADDR_CTRL: begin
            s_rdata[CTRL_KEEP] <= idle_clock_keep;
            s_rdata[CTRL_WDT]  <= wdt_enable;
            s_rdata[CTRL_VDE]  <= voltage_detect_enable;
          end
          ADDR_STATUS: begin
            s_rdata[0]   <= power_down_flag;
            s_rdata[1]   <= timeout_flag;
            s_rdata[4 +: 3] <= 3'(mode);
          end
          ADDR_WAKE: s_rdata[PA_W-1:0] <= porta_wake_enable;
          ADDR_CMD:  s_rdata <= 32'h0000_0000;
          default:   s_rresp <= AXI_SLVERR;
        endcase
      end else if (s_rvalid && s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------------------
  logic standby;
  assign standby = mode != ST_NORMAL && mode != ST_SLOW;

  // RULE_13 settings kept through standby
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      high_clock_select     <= 1'b0;
      idle_enable           <= 1'b1;
      clock_divider_select  <= CKS_RESET;
      idle_clock_keep       <= 1'b0;
      wdt_enable            <= 1'b1;
      voltage_detect_enable <= 1'b0;
      porta_wake_enable     <= '0;
    end else if (!standby) begin
      if (wr_mode) begin
        high_clock_select    <= w_q[MODE_HCS];
        idle_enable          <= w_q[MODE_IDLE];
        clock_divider_select <= w_q[MODE_CKS_L +: 3];
      end
      if (wr_ctrl) begin
        idle_clock_keep       <= w_q[CTRL_KEEP];
        wdt_enable            <= w_q[CTRL_WDT];
        voltage_detect_enable <= w_q[CTRL_VDE];
      end
      // RULE_18 per pin wake enable
      if (wr_wake) porta_wake_enable <= w_q[PA_W-1:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Wake sources
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pa_s1 <= '1;
      pa_s2 <= '1;
      pa_s3 <= '1;
    end else begin
      pa_s1 <= porta_pin;
      pa_s2 <= pa_s1;
      pa_s3 <= pa_s2;
    end
  end

  logic [PA_W-1:0] pa_fall;
  logic            pa_wake, irq_wake, wake, wdt_on, want_slow;
  // RULE_15 enabled falling edges
  assign pa_fall  = pa_s3 & ~pa_s2 & porta_wake_enable;
  assign pa_wake  = |pa_fall;
  assign irq_wake = |(irq_flag & irq_armed);
  assign wake     = pa_wake || irq_wake || wdt_overflow;
  assign wdt_on   = wdt_enable || WDT_ALWAYS;
  // RULE_03 sub clock selected by divider 000/001
  assign want_slow = !high_clock_select && clock_divider_select <= CKS_SUB_HI;

  // RULE_21 only flags clear at entry can wake
  always_ff @(posedge clk_sys) begin
    if (srst) irq_armed <= '0;
    else if (halt_req && !standby) irq_armed <= ~irq_flag;
  end

  // ---------------------------------------------------------------------------
  // Mode state machine
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mode <= ST_NORMAL;
    end else begin
      case (mode)
        ST_NORMAL, ST_SLOW: begin
          // RULE_01 standby only on halt
          if (halt_req) begin
            if (idle_enable)
              mode <= idle_clock_keep ? ST_IDLE_RUN : ST_IDLE_SUB; // RULE_12
            // RULE_07 no deep sleep with permanent watchdog
            else if (wdt_on || voltage_detect_enable)
              mode <= ST_SLEEP_SUB;  // RULE_10
            else
              mode <= ST_DEEP;       // RULE_08
          // RULE_04 slow entry waits for low oscillator ready
          end else if (want_slow && low_osc_ready) begin
            mode <= ST_SLOW;
          // RULE_05 back to normal
          end else if (!want_slow) begin
            mode <= ST_NORMAL;
          end
        end
        ST_DEEP, ST_SLEEP_SUB, ST_IDLE_SUB, ST_IDLE_RUN: begin
          // RULE_25 resume per held selection
          if (wake) mode <= want_slow ? ST_SLOW : ST_NORMAL;
        end
        default: mode <= ST_NORMAL;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Status flags
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      power_down_flag <= 1'b0;
      timeout_flag    <= 1'b0;
    end else begin
      // RULE_17 set by halt wins over clear
      if (halt_req && !standby) power_down_flag <= 1'b1;
      else if (clrwdt_req) power_down_flag <= 1'b0;
      // RULE_14 entry clears time-out; RULE_16 overflow sets it
      if (standby && wdt_overflow) timeout_flag <= 1'b1;
      else if (halt_req && !standby) timeout_flag <= 1'b0;
    end
  end

  // RULE_23 ready counters restart on leaving deep sleep, sub idle or slow (low counter: deep sleep only) or on reset
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      hrdy_cnt       <= '0;
      high_osc_ready <= 1'b0;
      lrdy_cnt       <= '0;
      low_osc_ready  <= 1'b0;
    end else begin
      if (mode == ST_DEEP || mode == ST_IDLE_SUB || mode == ST_SLOW) begin
        hrdy_cnt       <= '0;
        high_osc_ready <= 1'b0;
      end else if (hrdy_cnt != 5'(HRDY_CYC - 1)) begin
        hrdy_cnt <= hrdy_cnt + 5'd1;
      end else begin
        high_osc_ready <= 1'b1;
      end
      if (mode == ST_DEEP) begin
        lrdy_cnt      <= '0;
        low_osc_ready <= 1'b0;
      end else if (lrdy_cnt != 2'(LRDY_CYC - 1)) begin
        lrdy_cnt <= lrdy_cnt + 2'd1;
      end else begin
        low_osc_ready <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      clk_gate    <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
      core_ctl    <= '0;
      sys_div_sel <= CKS_RESET;
      vd_keep_on  <= 1'b0;
    end else begin
      // RULE_02 fast oscillator and dividers follow it
      clk_gate.high_osc_en <= mode == ST_NORMAL ||
                              (mode == ST_IDLE_RUN && !want_slow);
      clk_gate.div16_64_en <= mode == ST_NORMAL ||
                              (mode == ST_IDLE_RUN && !want_slow);
      clk_gate.sys_clk_en  <= !standby || mode == ST_IDLE_RUN;
      // RULE_24 detector forces sub clock
      clk_gate.sub_clk_en  <= mode != ST_DEEP || WDT_ALWAYS ||
                              voltage_detect_enable;
      clk_gate.cpu_run     <= !standby;
      vd_keep_on           <= voltage_detect_enable;
      // RULE_22 divider choice passed on
      sys_div_sel          <= clock_divider_select;
      // RULE_09 clear on every halt; hold while in deep sleep
      core_ctl.wdt_clear   <= (halt_req && !standby) || clrwdt_req;
      core_ctl.wdt_hold    <= mode == ST_DEEP;
      core_ctl.pc_sp_reset <= standby && wdt_overflow;
      // RULE_19 RULE_20 service only if enabled and stack free
      core_ctl.irq_take    <= standby && !wdt_overflow && !pa_wake &&
                              |(irq_flag & irq_armed & irq_enable) &&
                              !stack_full;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  sequence s_halt;
    halt_req && !standby;
  endsequence

  a_deep_entry: assert property (@(posedge clk_sys) disable iff (srst) // RULE_08
    s_halt ##0 (!idle_enable && !wdt_on && !voltage_detect_enable)
      |=> mode == ST_DEEP ##1 !clk_gate.sub_clk_en && !clk_gate.sys_clk_en)
    else $error("deep sleep not entered");
  a_no_deep: assert property (@(posedge clk_sys) disable iff (srst) // RULE_07
    wdt_on |-> mode != ST_DEEP)
    else $error("deep sleep with watchdog on");
  a_sleep_sub: assert property (@(posedge clk_sys) disable iff (srst) // RULE_10
    s_halt ##0 (!idle_enable && (wdt_on || voltage_detect_enable))
      |=> mode == ST_SLEEP_SUB ##1 clk_gate.sub_clk_en)
    else $error("sleep with sub clock not entered");
  a_idle_pick: assert property (@(posedge clk_sys) disable iff (srst) // RULE_11
    s_halt ##0 idle_enable |=>
      mode == (idle_clock_keep ? ST_IDLE_RUN : ST_IDLE_SUB))
    else $error("wrong idle mode");
  a_flags_entry: assert property (@(posedge clk_sys) disable iff (srst) // RULE_14
    s_halt |=> power_down_flag && !timeout_flag)
    else $error("flags wrong on entry");
  a_wdt_clear: assert property (@(posedge clk_sys) disable iff (srst) // RULE_09
    s_halt |=> core_ctl.wdt_clear)
    else $error("watchdog not cleared on halt");
  a_timeout_set: assert property (@(posedge clk_sys) disable iff (srst) // RULE_16
    standby && wdt_overflow |=> timeout_flag && core_ctl.pc_sp_reset)
    else $error("time-out not flagged");
  a_hrdy_time: assert property (@(posedge clk_sys) disable iff (srst) // RULE_23
    $fell(standby) && mode == ST_NORMAL |-> ##[15:17] high_osc_ready)
    else $error("high ready late");
  a_slow_ready: assert property (@(posedge clk_sys) disable iff (srst) // RULE_04
    mode != ST_SLOW ##1 mode == ST_SLOW |-> $past(low_osc_ready) || $past(wake))
    else $error("slow entered before low ready");
  a_resume_mode: assert property (@(posedge clk_sys) disable iff (srst) // RULE_25
    standby && wake |=> mode == ($past(want_slow) ? ST_SLOW : ST_NORMAL))
    else $error("wrong resume mode");
endmodule
`default_nettype wire

// ==== verification/power_mode_and_wake_controller_tb_top.sv ====
// Self-checking bench for the power mode and wake controller
`default_nettype none
module power_mode_and_wake_controller_tb_top import pwr_mode_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 0, srst = 1, stack_full = 0, wdt_overflow = 0;
  logic        s_awvalid = 0, s_wvalid = 0, s_bready = 0;
  logic        s_arvalid = 0, s_rready = 0;
  logic [7:0]  s_awaddr = 0, s_araddr = 0, porta_pin = 8'hff;
  logic [31:0] s_wdata = 0;
  logic [3:0]  s_wstrb = 0, irq_flag = 4'h1, irq_enable = 4'hf;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic        vd_keep_on;
  logic [1:0]  s_bresp, s_rresp;
  logic [31:0] s_rdata;
  logic [2:0]  sys_div_sel;
  clk_gate_t   clk_gate;
  core_ctl_t   core_ctl;
  logic [31:0] rq[$];
  logic [1:0]  bq[$];
  int          err_total = 0, comparisons = 0, irq_cnt = 0, pcr_cnt = 0;
  logic [7:0]  ctl_tab [5] = '{8'h00, 8'h01, 8'h02, 8'h00, 8'h80};
  logic [7:0]  mode_tab [5] = '{8'hc0, 8'hc0, 8'hc0, 8'hc2, 8'hc2};
  logic [2:0]  st_tab [5] = '{3'h2, 3'h3, 3'h3, 3'h4, 3'h5};
  int          src_tab [5] = '{0, 1, 2, 1, 0};

  always #4 clk_sys = ~clk_sys;

  power_mode_and_wake_controller dut (
    .clk_sys(clk_sys), .srst(srst), .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
    .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(s_rready), .porta_pin(porta_pin), .irq_flag(irq_flag),
    .irq_enable(irq_enable), .stack_full(stack_full),
    .wdt_overflow(wdt_overflow), .clk_gate(clk_gate),
    .core_ctl(core_ctl), .sys_div_sel(sys_div_sel),
    .vd_keep_on(vd_keep_on));

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim;
    $display("Counts: %0d compared, %0d mismatched", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // -------------------------------------------------------------------------
  // Response monitor
  // -------------------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (core_ctl.irq_take) irq_cnt++;
    if (core_ctl.pc_sp_reset) pcr_cnt++;
    if (s_rvalid && s_rready) begin
      chk("rresp", 32'(s_rresp), 32'(AXI_OKAY));
      chk("rdata", s_rdata, rq.pop_front());
    end
    if (s_bvalid && s_bready) chk("bresp", 32'(s_bresp), 32'(bq.pop_front()));
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = AXI_OKAY);
    int n;
    @(posedge clk_sys);
    bq.push_back(r);
    s_awaddr <= a;
    s_wdata <= d;
    s_wstrb <= 4'h1;
    s_awvalid <= 1;
    s_wvalid <= 1;
    s_bready <= 1;
    n = 0;
    do begin
      @(posedge clk_sys);
      if (s_awready && s_awvalid) s_awvalid <= 0;
      if (s_wready && s_wvalid) s_wvalid <= 0;
      n++;
    end while (!(s_bvalid && s_bready) && n < 200);
    if (n >= 200) err_total++;
    s_bready <= 0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    int n;
    @(posedge clk_sys);
    rq.push_back(e);
    s_araddr <= a;
    s_arvalid <= 1;
    s_rready <= 1;
    n = 0;
    do begin
      @(posedge clk_sys);
      if (s_arready && s_arvalid) s_arvalid <= 0;
      n++;
    end while (!(s_rvalid && s_rready) && n < 200);
    if (n >= 200) err_total++;
    s_rready <= 0;
  endtask

  // Generous bound; the whole run is a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    end_sim();
  end

  initial begin
    int   p;
    logic sf;
    void'($urandom(32'hfc63));
    repeat (16) @(posedge clk_sys);
    srst <= 0;
    repeat (20) @(posedge clk_sys);
    rd(ADDR_MODE, 32'h0000_00ce);
    rd(ADDR_CTRL, 32'h0000_0001);
    rd(ADDR_STATUS, 32'h0000_0000);
    wr(8'h20, 32'h0000_0000, AXI_SLVERR);
    $display("reset values test done");
    wr(ADDR_MODE, 32'h0000_0000);
    repeat (6) @(posedge clk_sys);
    rd(ADDR_STATUS, 32'h0000_0010);
    chk("high_osc_en", 32'(clk_gate.high_osc_en), 32'h0);
    chk("div16_64_en", 32'(clk_gate.div16_64_en), 32'h0);
    wr(ADDR_MODE, 32'h0000_00e0);
    repeat (20) @(posedge clk_sys);
    rd(ADDR_MODE, 32'h0000_00ec);
    rd(ADDR_STATUS, 32'h0000_0000);
    chk("sys_div_sel", 32'(sys_div_sel), 32'h7);
    $display("slow and normal switching test done");
    // Request flag 0 stays high throughout, so it must never wake
    for (int i = 0; i < 5; i++) begin
      p = $urandom_range(7);
      wr(ADDR_WAKE, 32'h0000_0001 << p);
      wr(ADDR_CTRL, 32'(ctl_tab[i]));
      wr(ADDR_MODE, 32'(mode_tab[i]));
      wr(ADDR_CMD, 32'h0000_0001);
      repeat (4) @(posedge clk_sys);
      rd(ADDR_STATUS, 32'({st_tab[i], 4'h1}));
      chk("clocks", 32'({clk_gate.sys_clk_en, clk_gate.sub_clk_en,
          clk_gate.cpu_run}), 32'({st_tab[i] == 5, st_tab[i] != 2, 1'b0}));
      chk("vd_keep_on", 32'(vd_keep_on), 32'(ctl_tab[i][1]));
      wr(ADDR_CTRL, 32'h0000_0083);
      case (src_tab[i])
        0: porta_pin[p] <= 1'b0;
        1: wdt_overflow <= 1'b1;
        default: begin
          sf = 1'($urandom_range(1));
          stack_full <= sf;
          irq_flag[1 + $urandom_range(2)] <= 1'b1;
        end
      endcase
      @(posedge clk_sys);
      wdt_overflow <= 1'b0;
      repeat (8) @(posedge clk_sys);
      porta_pin <= 8'hff;
      irq_flag <= 4'h1;
      rd(ADDR_STATUS, src_tab[i] == 1 ? 32'h3 : 32'h1);
      rd(ADDR_CTRL, 32'(ctl_tab[i]));
      $display("standby case %0d done", i);
    end
    chk("irq_take", 32'(irq_cnt), 32'(!sf));
    chk("pc_sp_reset", 32'(pcr_cnt), 32'h2);
    wr(ADDR_CMD, 32'h0000_0002);
    rd(ADDR_STATUS, 32'h0000_0000);
    $display("clear watchdog test done");
    end_sim();
  end
endmodule
`default_nettype wire
